// >>> core/dra_pkg.sv
/*
 Constants, command codes and state codes for the display RAM access
 and graphics acceleration command block.
 Assumes one clock at 40 MHz and a synchronous active-high reset.
*/
package dra_pkg;
   localparam logic [7:0] CMD_NOP     = 8'h00_E3;
   localparam logic [7:0] CMD_OPTIONS = 8'h00_23;
   localparam logic [7:0] CMD_DRAW    = 8'h00_24;
   localparam logic [7:0] CMD_COPY    = 8'h00_25;
   localparam logic [7:0] CMD_HSCROLL = 8'h00_26;
   localparam logic [7:0] CMD_STOP    = 8'h00_2E;
   localparam logic [7:0] CMD_START   = 8'h00_2F;
   localparam logic [7:0] CMD_COLADDR = 8'h00_15;
   localparam logic [7:0] CMD_ROWADDR = 8'h00_75;
   localparam logic [7:0] CMD_REMAP   = 8'h00_A0;
   localparam logic [7:0] CMD_DISPOFF = 8'h00_AE;
   localparam logic [7:0] CMD_DISPON  = 8'h00_AF;
   // Option, remap and status bit positions
   localparam int OPT_FILL_BIT = 0;
   localparam int OPT_WRAP_BIT = 1;
   localparam int OPT_REV_BIT  = 4;
   localparam int REMAP_VERT_BIT = 2;
   localparam int STAT_OFF_BIT = 6;
   // Geometry and reset values
   localparam int COL_W = 6;
   localparam int ROW_W = 7;
   localparam int ADDR_W = 13;
   localparam logic [5:0] COL_MAX = 6'h3_F;
   localparam logic [6:0] ROW_MAX = 7'h4_F;
   localparam logic [5:0] COL_END_RST = 6'h3_F;
   localparam logic [6:0] ROW_END_RST = 7'h4_F;
   localparam logic FILL_RST = 1'b1;
   // Frames per scroll step
   localparam logic [8:0] FRAMES_00 = 9'h00_C;
   localparam logic [8:0] FRAMES_01 = 9'h04_0;
   localparam logic [8:0] FRAMES_10 = 9'h08_0;
   localparam logic [8:0] FRAMES_11 = 9'h10_0;
   typedef enum logic [1:0] {
      ST_IDLE  = 2'b00,
      ST_DRAW  = 2'b01,
      ST_CP_RD = 2'b10,
      ST_CP_WR = 2'b11
   } dra_state_t;
endpackage

// >>> core/dra_ram.sv
/*
 Display memory: 64 columns by 128 rows of bytes, two pixels per byte.
 Assumes one shared port; read data appear one clock after the address.
*/
`timescale 1ns/1ps
module dra_ram
   import dra_pkg::*;
(
   input  wire logic              ref_clk_in,
   input  wire logic              we_in,
   input  wire logic [ADDR_W-1:0] addr_in,
   input  wire logic [7:0]        wdata_in,
   output logic      [7:0]        rdata_out
);
   logic [7:0] mem [0:(1<<ADDR_W)-1];

   // Registered read keeps the array free of reset, so it maps to block RAM
   always_ff @(posedge ref_clk_in)
   begin
      if (we_in)
      begin
         mem[addr_in] <= wdata_in;
      end
      rdata_out <= mem[addr_in];
   end
endmodule

// >>> core/dra_top.sv
/*
 Command interpreter for the graphics acceleration commands and the host
 path into display memory, with auto-advancing address pointers.
 Assumes host strobes are one-cycle pulses synchronous to ref_clk_in and
 frame_tick_in pulses once per display frame.
*/
`timescale 1ns/1ps
module dra_top
   import dra_pkg::*;
(
   input  wire logic       ref_clk_in,
   input  wire logic       srst_in,
   input  wire logic       wr_stb_in,
   input  wire logic       rd_stb_in,
   input  wire logic       dc_in,
   input  wire logic [7:0] data_in,
   input  wire logic       frame_tick_in,
   output logic      [7:0] rd_data_out,
   output logic            rd_valid_out,
   output logic            busy_out,
   output logic            display_on_out,
   output logic            scroll_active_out,
   output logic      [5:0] scroll_shift_out
);
   dra_state_t st, next_st;
   logic [7:0] cmd, next_cmd;
   logic [2:0] pidx, next_pidx;
   logic [7:0] p [0:5];
   logic [7:0] next_p [0:5];
   logic fill, wrap, rev, vert, next_fill, next_wrap, next_rev, next_vert;
   logic disp_on, next_disp_on, scr_act, next_scr_act;
   logic [5:0] col_start, col_end, col_ptr, next_col_start, next_col_end, next_col_ptr;
   logic [6:0] row_start, row_end, row_ptr, next_row_start, next_row_end, next_row_ptr;
   logic [5:0] scr_off, scr_shift, next_scr_off, next_scr_shift;
   logic [6:0] scr_rows, next_scr_rows;
   logic [1:0] scr_int, next_scr_int;
   logic [8:0] frame_cnt, next_frame_cnt, frames;
   logic [5:0] ec, next_ec;
   logic [6:0] er, next_er;
   logic [7:0] rd_latch, next_rd_latch, next_rd_data, rd_prev;
   logic rd_pend, next_rd_pend, next_rd_valid;
   logic mem_we;
   logic [ADDR_W-1:0] mem_addr;
   logic [7:0] mem_wdata, mem_rdata, pb;
   logic [2:0] need;
   logic [6:0] dcol, drow;
   logic last_c, last_r, on_edge;
   logic idle, cmd_wr, data_wr, data_rd, stat_rd, exec, op_wr;

   assign idle    = (st == ST_IDLE);
   assign cmd_wr  = wr_stb_in && !dc_in && idle;
   assign data_wr = wr_stb_in && dc_in && idle;
   assign data_rd = rd_stb_in && dc_in && idle && !wr_stb_in;
   assign stat_rd = rd_stb_in && !dc_in && !wr_stb_in;
   assign rd_prev = rd_pend ? mem_rdata : rd_latch;

   // Parameter bytes expected after each opcode
   always_comb
   begin
      unique case (cmd)
         CMD_COLADDR, CMD_ROWADDR: need = 3'd2;
         CMD_REMAP, CMD_OPTIONS:   need = 3'd1;
         CMD_DRAW:                 need = 3'd5;
         CMD_COPY:                 need = 3'd6;
         CMD_HSCROLL:              need = 3'd3;
         default:                  need = 3'd0;
      endcase
   end
   assign exec = cmd_wr && (pidx != 3'd0) && (pidx == need);
   assign op_wr = cmd_wr && ((pidx == 3'd0) || (need == 3'd0));

   // Interval code to frame count
   always_comb
   begin
      unique case (scr_int)
         2'b00: frames = FRAMES_00;
         2'b01: frames = FRAMES_01;
         2'b10: frames = FRAMES_10;
         2'b11: frames = FRAMES_11;
      endcase
   end

   // Engine walk position and copy destination
   assign last_c  = rev ? (ec == p[0][5:0]) : (ec == p[2][5:0]);
   assign last_r  = rev ? (er == p[1][6:0]) : (er == p[3][6:0]);
   assign on_edge = (ec == p[0][5:0]) || (ec == p[2][5:0])
                 || (er == p[1][6:0]) || (er == p[3][6:0]);
   assign dcol = 7'(p[4][5:0]) + 7'(ec - p[0][5:0]);
   assign drow = p[5][6:0] + (er - p[1][6:0]);

   // Command decode, pointers, engine, scroll and read path
   always_comb
   begin
      next_st = st;
      next_cmd = cmd;
      next_pidx = pidx;
      next_p = p;
      next_fill = fill;
      next_wrap = wrap;
      next_rev = rev;
      next_vert = vert;
      next_disp_on = disp_on;
      next_scr_act = scr_act;
      next_col_start = col_start;
      next_col_end = col_end;
      next_col_ptr = col_ptr;
      next_row_start = row_start;
      next_row_end = row_end;
      next_row_ptr = row_ptr;
      next_scr_off = scr_off;
      next_scr_rows = scr_rows;
      next_scr_int = scr_int;
      next_scr_shift = scr_shift;
      next_frame_cnt = frame_cnt;
      next_ec = ec;
      next_er = er;
      next_rd_latch = rd_pend ? mem_rdata : rd_latch;
      next_rd_pend = 1'b0;
      next_rd_valid = 1'b0;
      next_rd_data = rd_data_out;
      mem_we = 1'b0;
      mem_addr = {row_ptr, col_ptr};
      mem_wdata = data_in;
      pb = data_in;
      // Opcode unless parameters are still owed, so a code without parameters
      // never swallows the next opcode; E3 and unknown codes change nothing
      if (op_wr)
      begin
         next_cmd = data_in;
         next_pidx = 3'd1;
         unique case (data_in)
            CMD_DISPOFF: next_disp_on = 1'b0;
            CMD_DISPON:  next_disp_on = 1'b1;
            CMD_STOP:    next_scr_act = 1'b0;
            CMD_START:   next_scr_act = 1'b1;
            default:     next_scr_act = scr_act;
         endcase
      end
      else if (cmd_wr)
      begin
         next_p[pidx - 3'd1] = data_in;
         next_pidx = pidx + 3'd1;
      end
      // Last parameter byte applies the command
      if (exec)
      begin
         next_pidx = 3'd0;
         unique case (cmd)
            CMD_OPTIONS:
            begin
               next_fill = pb[OPT_FILL_BIT];
               next_wrap = pb[OPT_WRAP_BIT];
               next_rev  = pb[OPT_REV_BIT];
            end
            CMD_REMAP: next_vert = pb[REMAP_VERT_BIT];
            CMD_COLADDR:
            begin
               next_col_start = p[0][5:0];
               next_col_end = pb[5:0];
               next_col_ptr = p[0][5:0];
            end
            CMD_ROWADDR:
            begin
               next_row_start = p[0][6:0];
               next_row_end = pb[6:0];
               next_row_ptr = p[0][6:0];
            end
            CMD_DRAW:
            begin
               next_ec = p[0][5:0];
               next_er = p[1][6:0];
               next_st = ST_DRAW;
            end
            CMD_COPY:
            begin
               next_ec = next_rev ? p[2][5:0] : p[0][5:0];
               next_er = next_rev ? p[3][6:0] : p[1][6:0];
               next_st = ST_CP_RD;
            end
            CMD_HSCROLL:
            begin
               next_scr_off = p[0][5:0];
               next_scr_rows = p[1][6:0];
               next_scr_int = pb[1:0];
            end
            default: next_pidx = 3'd0;
         endcase
      end
      // Host data access at the pointers, then auto-advance
      if (data_wr || data_rd)
      begin
         mem_we = data_wr;
         if (data_rd)
         begin
            next_rd_data = rd_prev;
            next_rd_valid = 1'b1;
            next_rd_pend = 1'b1;
         end
         if (!vert)
         begin
            next_col_ptr = (col_ptr == col_end) ? col_start : col_ptr + 6'd1;
            if (col_ptr == col_end)
            begin
               next_row_ptr = (row_ptr == row_end) ? row_start : row_ptr + 7'd1;
            end
         end
         else
         begin
            next_row_ptr = (row_ptr == row_end) ? row_start : row_ptr + 7'd1;
            if (row_ptr == row_end)
            begin
               next_col_ptr = (col_ptr == col_end) ? col_start : col_ptr + 6'd1;
            end
         end
      end
      if (stat_rd)
      begin
         next_rd_data = 8'h0_0;
         next_rd_data[STAT_OFF_BIT] = !disp_on;
         next_rd_valid = 1'b1;
      end
      // Acceleration engine owns the memory port while busy
      unique case (st)
         ST_IDLE: next_ec = next_ec;
         ST_DRAW:
         begin
            mem_addr = {er, ec};
            mem_wdata = p[4];
            mem_we = fill || on_edge;
            // Draw always walks forward; reverse only applies to copy
            next_ec = (ec == p[2][5:0]) ? p[0][5:0] : ec + 6'd1;
            next_er = (ec == p[2][5:0]) ? er + 7'd1 : er;
            if ((ec == p[2][5:0]) && (er == p[3][6:0]))
            begin
               next_st = ST_IDLE;
            end
         end
         ST_CP_RD:
         begin
            mem_addr = {er, ec};
            next_st = ST_CP_WR;
         end
         ST_CP_WR:
         begin
            // Destinations past COL_MAX are dropped unless x-wrap is on; rows past ROW_MAX always are
            mem_addr = {drow, dcol[5:0]};
            mem_wdata = mem_rdata;
            mem_we = (wrap || !dcol[6]) && (drow <= ROW_MAX);
            next_st = ST_CP_RD;
            if (rev)
            begin
               next_ec = last_c ? p[2][5:0] : ec - 6'd1;
               next_er = last_c ? er - 7'd1 : er;
            end
            else
            begin
               next_ec = last_c ? p[0][5:0] : ec + 6'd1;
               next_er = last_c ? er + 7'd1 : er;
            end
            if (last_c && last_r)
            begin
               next_st = ST_IDLE;
            end
         end
      endcase
      // Scroll stepping only counts frames while shown
      if (scr_act && disp_on && frame_tick_in)
      begin
         next_frame_cnt = frame_cnt + 9'd1;
         if (frame_cnt + 9'd1 >= frames)
         begin
            next_frame_cnt = 9'd0;
            next_scr_shift = scr_shift + scr_off;
         end
      end
      if (!scr_act)
      begin
         next_frame_cnt = 9'd0;
      end
   end

   // State registers
   always_ff @(posedge ref_clk_in)
   begin
      if (srst_in)
      begin
         st <= ST_IDLE;
         cmd <= 8'h0_0;
         pidx <= 3'd0;
         p <= '{default: 8'h0_0};
         fill <= FILL_RST;
         wrap <= 1'b0;
         rev <= 1'b0;
         vert <= 1'b0;
         disp_on <= 1'b0;
         scr_act <= 1'b0;
         col_start <= 6'h0_0;
         col_end <= COL_END_RST;
         col_ptr <= 6'h0_0;
         row_start <= 7'h0_0;
         row_end <= ROW_END_RST;
         row_ptr <= 7'h0_0;
         scr_off <= 6'h0_0;
         scr_rows <= 7'h0_0;
         scr_int <= 2'b00;
         scr_shift <= 6'h0_0;
         frame_cnt <= 9'h00_0;
         ec <= 6'h0_0;
         er <= 7'h0_0;
         rd_latch <= 8'h0_0;
         rd_pend <= 1'b0;
         rd_data_out <= 8'h0_0;
         rd_valid_out <= 1'b0;
         busy_out <= 1'b0;
         display_on_out <= 1'b0;
         scroll_active_out <= 1'b0;
         scroll_shift_out <= 6'h0_0;
      end
      else
      begin
         st <= next_st;
         cmd <= next_cmd;
         pidx <= next_pidx;
         p <= next_p;
         fill <= next_fill;
         wrap <= next_wrap;
         rev <= next_rev;
         vert <= next_vert;
         disp_on <= next_disp_on;
         scr_act <= next_scr_act;
         col_start <= next_col_start;
         col_end <= next_col_end;
         col_ptr <= next_col_ptr;
         row_start <= next_row_start;
         row_end <= next_row_end;
         row_ptr <= next_row_ptr;
         scr_off <= next_scr_off;
         scr_rows <= next_scr_rows;
         scr_int <= next_scr_int;
         scr_shift <= next_scr_shift;
         frame_cnt <= next_frame_cnt;
         ec <= next_ec;
         er <= next_er;
         rd_latch <= next_rd_latch;
         rd_pend <= next_rd_pend;
         rd_data_out <= next_rd_data;
         rd_valid_out <= next_rd_valid;
         busy_out <= (next_st != ST_IDLE);
         display_on_out <= next_disp_on;
         scroll_active_out <= next_scr_act;
         scroll_shift_out <= next_scr_shift;
      end
   end

   dra_ram u_ram (
      .ref_clk_in (ref_clk_in),
      .we_in      (mem_we),
      .addr_in    (mem_addr),
      .wdata_in   (mem_wdata),
      .rdata_out  (mem_rdata)
   );

   // Checks
   default clocking cb @(posedge ref_clk_in); endclocking
   default disable iff (srst_in);

   a_nop_no_change: assert property (op_wr && data_in == CMD_NOP |=>
      $stable(col_ptr) && $stable(row_ptr) && $stable(scr_act) && $stable(disp_on))
      else $error("nop changed state");
   a_fill_reset: assert property ($past(srst_in) |-> fill && !wrap && !rev && !vert)
      else $error("option reset values wrong");
   a_draw_starts: assert property (exec && cmd == CMD_DRAW |=> busy_out && st == ST_DRAW)
      else $error("draw did not start");
   a_stop_scroll: assert property (op_wr && data_in == CMD_STOP |=>
      !scroll_active_out) else $error("scroll not stopped");
   a_scroll_off: assert property (!disp_on |=> $stable(scroll_shift_out))
      else $error("scroll moved with display off");
   a_status_bit: assert property (stat_rd |=> rd_valid_out &&
      rd_data_out[STAT_OFF_BIT] == !$past(disp_on)) else $error("status bit wrong");
   a_status_keep: assert property (stat_rd && !(wr_stb_in && dc_in) |=>
      $stable(col_ptr) && $stable(row_ptr)) else $error("status read moved pointer");
   a_read_lag: assert property (data_rd |=> rd_data_out == $past(rd_prev))
      else $error("read data not one access late");
   a_col_step: assert property ((data_wr || data_rd) && !vert && col_ptr != col_end |=>
      col_ptr == $past(col_ptr) + 6'd1 && $stable(row_ptr)) else $error("column step wrong");
   a_col_wrap: assert property ((data_wr || data_rd) && !vert && col_ptr == col_end
      && row_ptr != row_end |=> col_ptr == col_start && row_ptr == $past(row_ptr) + 7'd1)
      else $error("column wrap wrong");
   c_draw: cover property (st == ST_DRAW ##1 st == ST_IDLE);
   c_copy: cover property (st == ST_CP_WR && rev);
   c_scroll: cover property (scr_act && $changed(scr_shift));
   c_read: cover property (data_rd ##1 data_rd);
endmodule

// >>> tb/dra_host.sv
/*
 Host model: issues command and data writes, status and data reads,
 and display frame pulses toward dra_top.
 Assumes every strobe is a one-cycle pulse sampled on the rising edge.
*/
`timescale 1ns/1ps
module dra_host
(
   input  wire logic       ref_clk_in,
   input  wire logic       busy_in,
   input  wire logic       rd_valid_in,
   input  wire logic [7:0] rd_data_in,
   output logic            wr_stb_out,
   output logic            rd_stb_out,
   output logic            dc_out,
   output logic      [7:0] data_out,
   output logic            frame_tick_out
);
   // Quiet bus at time zero
   initial
   begin
      wr_stb_out = 1'b0;
      rd_stb_out = 1'b0;
      dc_out = 1'b0;
      data_out = 8'hA5;
      frame_tick_out = 1'b0;
   end

   // Wait while the engine owns memory; bounded so a stuck busy cannot hang
   task automatic step();
      int k;
      k = 0;
      @(posedge ref_clk_in);
      #1;
      while (busy_in !== 1'b0 && k < 2000)
      begin
         @(posedge ref_clk_in);
         #1;
         k++;
      end
   endtask

   // One byte; select high means data, low means a command or parameter byte
   task automatic wr(input logic d, input logic [7:0] b);
      step();
      wr_stb_out = 1'b1;
      dc_out = d;
      data_out = b;
      @(posedge ref_clk_in);
      #1;
      wr_stb_out = 1'b0;
      data_out = ~b; // Released bus must not look like the last byte
   endtask

   // One read; the answer is taken the cycle after the strobe
   task automatic rd(input logic d, output logic [7:0] q, output logic v);
      step();
      rd_stb_out = 1'b1;
      dc_out = d;
      @(posedge ref_clk_in);
      #1;
      rd_stb_out = 1'b0;
      q = rd_data_in;
      v = rd_valid_in;
   endtask

   // Frame pulses, then settle time for the shift register
   task automatic ticks(input int n);
      repeat (n)
      begin
         @(posedge ref_clk_in);
         #1;
         frame_tick_out = 1'b1;
         @(posedge ref_clk_in);
         #1;
         frame_tick_out = 1'b0;
      end
      repeat (2) @(posedge ref_clk_in);
      #1;
   endtask
endmodule

// >>> tb/dra_top_tb_top.sv
/*
 Self-checking bench for dra_top: status, pointers, draw, copy, scroll.
 Assumes dra_host on the host side; assertions live in the design.
*/
`timescale 1ns/1ps
module dra_top_tb_top
   import dra_pkg::*;
;
   logic       ref_clk_in = 1'b0;
   logic       srst_in;
   logic       wr_stb, rd_stb, dc, frame_tick;
   logic [7:0] data, rd_data;
   logic       rd_valid, busy, disp_on, scr_act;
   logic [5:0] shift, sh, off;
   int         n_mismatch = 0;
   int         checks_done = 0;
   int         nfr[4] = '{FRAMES_00, FRAMES_01, FRAMES_10, FRAMES_11};

   always #12.5 ref_clk_in = ~ref_clk_in;

   dra_top u_dut (.ref_clk_in(ref_clk_in), .srst_in(srst_in), .wr_stb_in(wr_stb),
      .rd_stb_in(rd_stb), .dc_in(dc), .data_in(data), .frame_tick_in(frame_tick),
      .rd_data_out(rd_data), .rd_valid_out(rd_valid), .busy_out(busy),
      .display_on_out(disp_on), .scroll_active_out(scr_act), .scroll_shift_out(shift));

   dra_host u_host (.ref_clk_in(ref_clk_in), .busy_in(busy), .rd_valid_in(rd_valid),
      .rd_data_in(rd_data), .wr_stb_out(wr_stb), .rd_stb_out(rd_stb), .dc_out(dc),
      .data_out(data), .frame_tick_out(frame_tick));

   // Single comparison point; four-state so unknowns never match
   task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
      checks_done++;
      if (seen !== exp)
      begin
         n_mismatch++;
         $display("mismatch %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic cmd(input logic [7:0] b);
      u_host.wr(1'b0, b);
   endtask

   task automatic dat(input logic [7:0] b);
      u_host.wr(1'b1, b);
   endtask

   task automatic settle();
      repeat (2) @(posedge ref_clk_in);
      #1;
   endtask

   // Data read; answer is the byte fetched by the read before
   task automatic rdat(input logic [7:0] exp, input string nm);
      logic [7:0] q;
      logic       v;
      u_host.rd(1'b1, q, v);
      check("rd_valid", {7'h00, v}, 8'h01);
      check(nm, q, exp);
   endtask

   task automatic rdum();
      logic [7:0] q;
      logic       v;
      u_host.rd(1'b1, q, v);
   endtask

   task automatic stat(input logic [7:0] exp);
      logic [7:0] q;
      logic       v;
      u_host.rd(1'b0, q, v);
      check("status", q, exp);
   endtask

   // Column and row window; also reloads both pointers
   task automatic win(input logic [7:0] c0, c1, r0, r1);
      cmd(CMD_COLADDR);
      cmd(c0);
      cmd(c1);
      cmd(CMD_ROWADDR);
      cmd(r0);
      cmd(r1);
   endtask

   // Busy length in cycles; negative expectation only waits
   task automatic eng(input int exp, input string nm);
      int k;
      int n;
      k = 0;
      n = 0;
      while (busy !== 1'b1 && k < 4)
      begin
         @(posedge ref_clk_in);
         #1;
         k++;
      end
      while (busy === 1'b1 && n < 1000)
      begin
         @(posedge ref_clk_in);
         #1;
         n++;
      end
      if (exp > 0)
         check(nm, 8'(n), 8'(exp));
   endtask

   task automatic final_report();
      $display("checks %0d mismatches %0d", checks_done, n_mismatch);
      if (n_mismatch == 0 && checks_done > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   // Watchdog sized well beyond the expected run
   initial
   begin
      #2000000;
      n_mismatch++;
      final_report();
   end

   initial
   begin
      srst_in = 1'b1;
      repeat (5) @(posedge ref_clk_in);
      #1;
      srst_in = 1'b0;
      check("scroll_rst", {7'h00, scr_act}, 8'h00);
      check("disp_rst", {7'h00, disp_on}, 8'h00);
      stat(8'h40);
      cmd(CMD_DISPON);
      check("disp_on", {7'h00, disp_on}, 8'h01);
      stat(8'h00);
      // Pointer walk with command and status traffic in between
      win(8'h02, 8'h03, 8'h01, 8'h02);
      dat(8'h01);
      dat(8'h02);
      cmd(CMD_NOP);
      stat(8'h00);
      dat(8'h03);
      dat(8'h04);
      dat(8'h05);
      win(8'h02, 8'h03, 8'h01, 8'h02);
      rdum();
      rdat(8'h05, "horiz0");
      rdat(8'h02, "horiz1");
      rdat(8'h03, "horiz2");
      rdat(8'h04, "horiz3");
      rdat(8'h05, "horiz_wrap");
      // Vertical increment reads column by column
      cmd(CMD_REMAP);
      cmd(8'h04);
      win(8'h02, 8'h03, 8'h01, 8'h02);
      rdum();
      rdat(8'h05, "vert0");
      rdat(8'h03, "vert1");
      rdat(8'h02, "vert2");
      rdat(8'h04, "vert3");
      cmd(CMD_REMAP);
      cmd(8'h00);
      // Filled rectangle with fill left at its reset value
      cmd(CMD_DRAW);
      cmd(8'h00);
      cmd(8'h00);
      cmd(8'h02);
      cmd(8'h01);
      cmd(8'hA5);
      eng(6, "draw_cycles");
      win(8'h00, 8'h02, 8'h00, 8'h01);
      rdum();
      repeat (6) rdat(8'hA5, "fill");
      // Clear a 3x3 area, then draw its border only
      cmd(CMD_DRAW);
      cmd(8'h00);
      cmd(8'h00);
      cmd(8'h02);
      cmd(8'h02);
      cmd(8'h00);
      eng(9, "clear_cycles");
      cmd(CMD_OPTIONS);
      cmd(8'h00);
      cmd(CMD_DRAW);
      cmd(8'h00);
      cmd(8'h00);
      cmd(8'h02);
      cmd(8'h02);
      cmd(8'h3C);
      eng(-1, "");
      win(8'h00, 8'h02, 8'h00, 8'h02);
      rdum();
      for (int i = 0; i < 9; i++)
         rdat((i == 4) ? 8'h00 : 8'h3C, "border");
      // Copy forward, then reversed with wrap on
      for (int p = 0; p < 2; p++)
      begin
         if (p == 1)
         begin
            cmd(CMD_OPTIONS);
            cmd(8'h12);
         end
         cmd(CMD_COPY);
         cmd(8'h00);
         cmd(8'h00);
         cmd(8'h01);
         cmd(8'h01);
         cmd(8'(4 + 4 * p));
         cmd(8'(4 + 4 * p));
         eng(8, "copy_cycles");
         win(8'(4 + 4 * p), 8'(5 + 4 * p), 8'(4 + 4 * p), 8'(5 + 4 * p));
         rdum();
         for (int i = 0; i < 4; i++)
            rdat((i == 3) ? 8'h00 : 8'h3C, "copy");
      end
      // Each interval code: no step one frame early, one step on time
      sh = 6'h00;
      for (int c = 0; c < 4; c++)
      begin
         off = 6'(5 * c + 3);
         cmd(CMD_STOP);
         settle();
         check("scroll_stop", {7'h00, scr_act}, 8'h00);
         cmd(CMD_HSCROLL);
         cmd({2'b00, off});
         cmd(8'h02);
         cmd(8'(c));
         cmd(CMD_START);
         settle();
         check("scroll_start", {7'h00, scr_act}, 8'h01);
         u_host.ticks(nfr[c] - 1);
         check("shift_early", {2'b00, shift}, {2'b00, sh});
         u_host.ticks(1);
         sh = sh + off;
         check("shift_step", {2'b00, shift}, {2'b00, sh});
      end
      // Display off freezes the scroll; stop freezes it too
      cmd(CMD_STOP);
      cmd(CMD_HSCROLL);
      cmd(8'h07);
      cmd(8'h02);
      cmd(8'h00);
      cmd(CMD_START);
      cmd(CMD_DISPOFF);
      check("disp_off", {7'h00, disp_on}, 8'h00);
      stat(8'h40);
      u_host.ticks(12);
      check("shift_off", {2'b00, shift}, {2'b00, sh});
      cmd(CMD_DISPON);
      u_host.ticks(12);
      sh = sh + 6'h07;
      check("shift_on", {2'b00, shift}, {2'b00, sh});
      cmd(CMD_STOP);
      u_host.ticks(12);
      check("shift_stop", {2'b00, shift}, {2'b00, sh});
      win(8'h00, 8'h00, 8'h00, 8'h00);
      dat(8'h00);
      final_report();
   end
endmodule
